// file: enable_latch.sv
// enable_latch: transparent-while-strobe enable latch, captured on strobe low
// assumes: strobe and d already synchronised to aclk
`timescale 1ns/1ps
`default_nettype none
module enable_latch #(
  parameter int W = 4,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clr,
  input wire logic strobe,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q_r
);
  always_ff @(posedge aclk) begin
    if (!aresetn || clr) begin
      q_r <= RST;
    end else if (strobe) begin
      q_r <= d;
    end
  end

  property p_latch_hold;
    @(posedge aclk) disable iff (!aresetn)
      (!strobe && !clr) |=> $stable(q_r);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("enable latch changed while strobe low");
endmodule : enable_latch
`default_nettype wire

// file: link_char_src.sv
// link_char_src: far-end character source for both receive channels
// assumes: one character per 160 ns call, channels may run in parallel
`timescale 1ns/1ps
`default_nettype none
module link_char_src (
  output var logic [1:0] rec_clk,
  output var logic [1:0][9:0] raw,
  output var logic [1:0][7:0] dd,
  output var logic [1:0][2:0] ds
);
  initial begin
    rec_clk = 2'h0;
    raw = '0;
    dd = '0;
    ds = '0;
  end
  // ****************************************
  // one character
  // ****************************************
  // clock stands low between characters; data inverted once hold ends
  // so a late sample never sees a stale match
  task automatic send(input int c, input logic [9:0] r, input logic [7:0] d,
    input logic [2:0] s);
    #3;
    raw[c] = r;
    dd[c] = d;
    ds[c] = s;
    #40;
    rec_clk[c] = 1'b1;
    #80;
    rec_clk[c] = 1'b0;
    raw[c] = ~r;
    dd[c] = ~d;
    ds[c] = ~s;
    #37;
  endtask : send
endmodule : link_char_src
`default_nettype wire

// file: rx_out_reg.sv
// rx_out_reg: one channel's 12-bit output register plus parity drive enable
// assumes: word fields stable in the cycle that load is high
`timescale 1ns/1ps
`default_nettype none
module rx_out_reg (
  input wire logic aclk,
  input wire logic aresetn,
  rx_word_if.dst w,
  output logic [7:0] data_r,
  output logic [2:0] status_r,
  output logic parity_r,
  output logic parity_oe_r
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_r <= 8'h00;
      status_r <= 3'h0;
      parity_r <= 1'b1;
      parity_oe_r <= 1'b0;
    end else begin
      parity_oe_r <= w.parity_oe;
      if (w.load) begin
        data_r <= w.data;
        status_r <= w.status;
        parity_r <= w.parity;
      end
    end
  end

  property p_load_together;
    @(posedge aclk) disable iff (!aresetn)
      w.load |=> (data_r == $past(w.data)) && (status_r == $past(w.status))
        && (parity_r == $past(w.parity));
  endproperty
  a_load_together: assert property (p_load_together)
    else $error("output register fields did not load together");
endmodule : rx_out_reg
`default_nettype wire

// file: rx_output_parity_power_latch.sv
// rx_output_parity_power_latch: channel power latches, receive output
// formatting, odd parity and output clock alignment for two channels
// assumes: link pins asynchronous to aclk, recovered clock far slower than aclk
//
// Function
// - with rx strobe high, enable bus bits drive receive channel power enables
// - enable bit high powers the receive channel up, low powers it down
// - rx strobe falling captures and holds the last enable bus values
// - disabled receive channel drives its link fault output constant
// - with tx strobe high, enable bus bits drive the serial drivers
// - both drivers of a channel off powers down its transmit logic
// - tx strobe falling latches and holds the enable bus values
// - device reset clears both enable latches and presets self-test latch
// - each channel outputs eight data, three status and one parity bit
// - bypass mode maps raw a,b to status 1,0 and c..j to data 0..7
// - frame detect high only for the selected framing character
// - low-latency half-rate framer stretches clock so rise meets frame detect, with clock select mid or high only
// - multi-byte half-rate framer shifts data one stage instead of the clock
// - boundary adjustments only while the framer is enabled
// - parity control low disables parity and floats every parity output
// - mid level with decoder on gives odd parity over data bits
// - mid level with decoder bypassed covers data and status bits 1,0
// - high level covers data and all three status bits
// - parity is always odd
// - parity sits in the same output register as data and status
// - bypass without self-test drives status 2 low except framing chars
`timescale 1ns/1ps
`default_nettype none
module rx_output_parity_power_latch #(
  parameter int CH = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic device_reset_n,
  input wire logic rx_latch_strobe,
  input wire logic tx_latch_strobe,
  input wire logic [3:0] chan_enable_bus,
  input wire logic [CH-1:0] rec_clk,
  input wire logic [CH-1:0] sig_detect,
  input wire logic [CH-1:0][9:0] link_raw_char,
  input wire logic [CH-1:0][7:0] link_dec_data,
  input wire logic [CH-1:0][2:0] link_dec_status,
  output logic [CH-1:0] rx_power_en,
  output logic [3:0] tx_driver_en,
  output logic [CH-1:0] tx_logic_power,
  output logic [CH-1:0] link_fault_ind_n,
  output logic [CH-1:0] rx_output_clock,
  output logic [CH-1:0][7:0] rx_data_bits,
  output logic [CH-1:0][2:0] rx_status_bits,
  output logic [CH-1:0] rx_parity_out,
  output logic [CH-1:0] rx_parity_out_oe
);

  // ****************************************
  // helpers
  // ****************************************
  localparam int SW = 7 + CH * 23;

  function automatic logic odd_par(input logic [10:0] v, input logic [10:0] m);
    odd_par = ~(^(v & m));
  endfunction : odd_par

  function automatic logic is_frame(input logic [9:0] c, input logic full);
    if (full) begin
      is_frame = (c == rxfmt_pkg::K285_POS) || (c == rxfmt_pkg::K285_NEG);
    end else begin
      is_frame = (c[6:0] == rxfmt_pkg::COMMA_POS)
        || (c[6:0] == rxfmt_pkg::COMMA_NEG);
    end
  endfunction : is_frame

  // ****************************************
  // pin synchroniser
  // ****************************************
  // data rides the same two stages as its clock so edges and words stay paired
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  wire [SW-1:0] pins = {device_reset_n, rx_latch_strobe, tx_latch_strobe,
    chan_enable_bus, rec_clk, sig_detect, link_raw_char, link_dec_data,
    link_dec_status};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
    end
  end

  wire rst_n_s = sync2_r[SW-1];
  wire rx_stb_s = sync2_r[SW-2];
  wire tx_stb_s = sync2_r[SW-3];
  wire [3:0] bus_s = sync2_r[SW-4 -: 4];
  wire [CH-1:0] rclk_s = sync2_r[CH*22 +: CH];
  wire [CH-1:0] sdet_s = sync2_r[CH*21 +: CH];
  wire [CH-1:0][9:0] raw_s = sync2_r[CH*11 +: CH*10];
  wire [CH-1:0][7:0] ddat_s = sync2_r[CH*3 +: CH*8];
  wire [CH-1:0][2:0] dst_s = sync2_r[0 +: CH*3];

  // ****************************************
  // register bus
  // ****************************************
  logic [31:0] ctrl_r;
  logic aw_have_r;
  logic [3:0] aw_addr_r;
  logic w_have_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bist_off_r;
  logic [3:0] rx_q;
  logic [3:0] tx_q;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire do_write = aw_have_r && w_have_r && !s_axi_bvalid;
  wire wr_ctrl = do_write && (aw_addr_r == rxfmt_pkg::CTRL_ADDR);
  wire wr_ok = wr_ctrl || (aw_addr_r == rxfmt_pkg::STAT_ADDR);
  wire rd_ctrl = s_axi_araddr == rxfmt_pkg::CTRL_ADDR;
  wire rd_stat = s_axi_araddr == rxfmt_pkg::STAT_ADDR;
  wire [31:0] stat_w = {19'h0, tx_logic_power, bist_off_r, tx_q, 2'h0, rx_q};
  wire [31:0] strb_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
    {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  wire [31:0] ctrl_nxt = (ctrl_r & ~strb_mask) | (w_data_r & strb_mask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rxfmt_pkg::RESP_OKAY;
      ctrl_r <= rxfmt_pkg::CTRL_RST;
    end else begin
      s_axi_awready <= !s_axi_awready && s_axi_awvalid && !aw_have_r;
      s_axi_wready <= !s_axi_wready && s_axi_wvalid && !w_have_r;
      if (aw_take) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? rxfmt_pkg::RESP_OKAY : rxfmt_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl_r <= ctrl_nxt;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= rxfmt_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_ctrl ? ctrl_r : (rd_stat ? stat_w : 32'h0000_0000);
        s_axi_rresp <= (rd_ctrl || rd_stat) ? rxfmt_pkg::RESP_OKAY
          : rxfmt_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  wire [1:0] dec_sel = ctrl_r[rxfmt_pkg::CTRL_DEC_LSB +: 2];
  wire [1:0] par_ctl = ctrl_r[rxfmt_pkg::CTRL_PAR_LSB +: 2];
  wire fpat_full = ctrl_r[rxfmt_pkg::CTRL_FPAT_BIT];
  wire [1:0] fmode = ctrl_r[rxfmt_pkg::CTRL_FMODE_LSB +: 2];
  wire half_rate = ctrl_r[rxfmt_pkg::CTRL_HALF_BIT];
  wire [1:0] cksel = ctrl_r[rxfmt_pkg::CTRL_CKSEL_LSB +: 2];
  wire framer_en = ctrl_r[rxfmt_pkg::CTRL_FEN_BIT];
  wire bypass = dec_sel == rxfmt_pkg::LVL_LOW;

  // ****************************************
  // power latches
  // ****************************************
  // device reset pin only clears latches; bus registers keep their contents
  enable_latch #(.W(4), .RST(rxfmt_pkg::RX_EN_RST)) u_rx_latch (
    .aclk(aclk), .aresetn(aresetn), .clr(!rst_n_s),
    .strobe(rx_stb_s), .d(bus_s), .q_r(rx_q)
  );
  enable_latch #(.W(4), .RST(rxfmt_pkg::TX_EN_RST)) u_tx_latch (
    .aclk(aclk), .aresetn(aresetn), .clr(!rst_n_s),
    .strobe(tx_stb_s), .d(bus_s), .q_r(tx_q)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn || !rst_n_s) begin
      bist_off_r <= rxfmt_pkg::BIST_OFF_RST;
    end else if (wr_ctrl) begin
      bist_off_r <= !ctrl_nxt[rxfmt_pkg::CTRL_BIST_BIT];
    end
  end

  assign tx_driver_en = tx_q;

  // ****************************************
  // receive channels
  // ****************************************
  logic [CH-1:0] rclk_d_r;
  logic [CH-1:0] load_w;
  logic [CH-1:0] stretch_w;
  logic [CH-1:0] chan_en;

  genvar c;
  generate
    for (c = 0; c < CH; c++) begin : g_ch
      rx_word_if wif ();
      logic phase_r;
      logic pipe_sel_r;
      logic [10:0] prev_r;
      logic prev_frame_r;

      assign chan_en[c] = rx_q[2*c];
      assign rx_power_en[c] = rx_q[2*c];
      wire rise = rclk_s[c] && !rclk_d_r[c];
      wire cur_frame = is_frame(raw_s[c], fpat_full);
      wire st2 = bist_off_r ? cur_frame : dst_s[c][2];
      wire [10:0] cur_word = bypass
        ? {st2, raw_s[c][0], raw_s[c][1], raw_s[c][9:2]}
        : {dst_s[c], ddat_s[c]};
      wire [10:0] word = pipe_sel_r ? prev_r : cur_word;
      wire sel_frame = pipe_sel_r ? prev_frame_r : cur_frame;
      wire adj = framer_en && half_rate;
      wire lowlat = fmode == rxfmt_pkg::LVL_LOW;
      wire stretch = adj && lowlat && (cksel != rxfmt_pkg::LVL_LOW)
        && sel_frame && phase_r;
      wire shift = adj && !lowlat && sel_frame && phase_r;
      wire [10:0] pmask = (par_ctl == rxfmt_pkg::LVL_HIGH) ? 11'h7ff
        : (bypass ? 11'h3ff : 11'h0ff);
      wire load = rise && chan_en[c];
      wire phase_nxt = load ? (stretch ? 1'b1 : !phase_r) : phase_r;
      wire gap_nxt = load && stretch;

      assign load_w[c] = load;
      assign stretch_w[c] = stretch;
      assign wif.data = word[7:0];
      assign wif.status = word[10:8];
      assign wif.parity = odd_par(word, pmask);
      assign wif.parity_oe = par_ctl != rxfmt_pkg::LVL_LOW;
      assign wif.load = load;

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          rclk_d_r[c] <= 1'b0;
          phase_r <= 1'b0;
          pipe_sel_r <= 1'b0;
          prev_r <= 11'h000;
          prev_frame_r <= 1'b0;
          rx_output_clock[c] <= 1'b0;
          link_fault_ind_n[c] <= 1'b0;
          tx_logic_power[c] <= 1'b0;
        end else begin
          rclk_d_r[c] <= rclk_s[c];
          phase_r <= phase_nxt;
          if (load) begin
            prev_r <= cur_word;
            prev_frame_r <= cur_frame;
            if (shift) begin
              pipe_sel_r <= !pipe_sel_r;
            end
          end
          if (!adj) begin
            pipe_sel_r <= 1'b0;
          end
          // half rate: clock level tracks character phase, dipped when stretched
          rx_output_clock[c] <= half_rate ? (phase_nxt && !gap_nxt)
            : rclk_s[c];
          link_fault_ind_n[c] <= chan_en[c] && sdet_s[c];
          tx_logic_power[c] <= |tx_q[2*c +: 2];
        end
      end

      rx_out_reg u_oreg (
        .aclk(aclk),
        .aresetn(aresetn),
        .w(wif),
        .data_r(rx_data_bits[c]),
        .status_r(rx_status_bits[c]),
        .parity_r(rx_parity_out[c]),
        .parity_oe_r(rx_parity_out_oe[c])
      );
    end
  endgenerate

  // ****************************************
  // checks on the enable latches and on channel 0
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_rx_open;
    rx_stb_s && rst_n_s;
  endsequence
  sequence s_stretch_load;
    load_w[0] && stretch_w[0];
  endsequence

  property p_rx_follow;
    s_rx_open |=> rx_q == $past(bus_s);
  endproperty
  a_rx_follow: assert property (p_rx_follow)
    else $error("rx latch not transparent");

  property p_rx_power;
    s_rx_open ##0 !bus_s[0] |=> !rx_power_en[0];
  endproperty
  a_rx_power: assert property (p_rx_power)
    else $error("rx channel not powered down");

  property p_tx_follow;
    tx_stb_s && rst_n_s |=> tx_driver_en == $past(bus_s);
  endproperty
  a_tx_follow: assert property (p_tx_follow)
    else $error("tx latch not transparent");

  property p_tx_hold;
    !tx_stb_s && rst_n_s |=> $stable(tx_driver_en);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx latch changed while closed");

  property p_dev_reset;
    !rst_n_s |=> (rx_q == 4'h0) && (tx_q == 4'h0) && bist_off_r;
  endproperty
  a_dev_reset: assert property (p_dev_reset)
    else $error("device reset left latches set");

  property p_fault_const;
    !chan_en[0] [*2] |=> !link_fault_ind_n[0];
  endproperty
  a_fault_const: assert property (p_fault_const)
    else $error("disabled channel fault output not constant");

  property p_tx_logic_off;
    tx_q[1:0] == 2'h0 |=> !tx_logic_power[0];
  endproperty
  a_tx_logic_off: assert property (p_tx_logic_off)
    else $error("transmit logic powered with both drivers off");

  property p_par_float;
    par_ctl == rxfmt_pkg::LVL_LOW |=> !rx_parity_out_oe[0];
  endproperty
  a_par_float: assert property (p_par_float)
    else $error("parity output driven while disabled");

  property p_par_odd_all;
    load_w[0] && (par_ctl == rxfmt_pkg::LVL_HIGH) |=>
      ^{rx_status_bits[0], rx_data_bits[0], rx_parity_out[0]};
  endproperty
  a_par_odd_all: assert property (p_par_odd_all)
    else $error("parity not odd over data and status");

  property p_par_odd_data;
    load_w[0] && (par_ctl == rxfmt_pkg::LVL_MID) && !bypass |=>
      ^{rx_data_bits[0], rx_parity_out[0]};
  endproperty
  a_par_odd_data: assert property (p_par_odd_data)
    else $error("parity not odd over data");

  property p_stretch;
    s_stretch_load |=> !rx_output_clock[0] ##1 rx_output_clock[0];
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("stretched clock did not rise at frame");

endmodule : rx_output_parity_power_latch
`default_nettype wire

// file: rx_word_if.sv
// rx_word_if: one channel's formatted word on its way to the output register
// assumes: both ends on aclk
`timescale 1ns/1ps
`default_nettype none
interface rx_word_if;
  logic [7:0] data;
  logic [2:0] status;
  logic parity;
  logic parity_oe;
  logic load;
  modport src (output data, status, parity, parity_oe, load);
  modport dst (input data, status, parity, parity_oe, load);
endinterface : rx_word_if
`default_nettype wire

// file: rxfmt_pkg.sv
// rxfmt_pkg: register map, field positions, reset values, level codes
// assumes: 32-bit AXI4-Lite register bus, two receive channels
package rxfmt_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STAT_ADDR = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // control fields
  // ****************************************
  localparam int CTRL_DEC_LSB = 0;
  localparam int CTRL_PAR_LSB = 2;
  localparam int CTRL_FPAT_BIT = 4;
  localparam int CTRL_FMODE_LSB = 5;
  localparam int CTRL_HALF_BIT = 7;
  localparam int CTRL_CKSEL_LSB = 8;
  localparam int CTRL_FEN_BIT = 10;
  localparam int CTRL_BIST_BIT = 11;
  localparam logic [31:0] CTRL_RST = 32'h0000_0105;

  // ****************************************
  // three-level input codes
  // ****************************************
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_MID = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;

  // ****************************************
  // latch reset values and framing patterns
  // ****************************************
  localparam logic [3:0] RX_EN_RST = 4'h0;
  localparam logic [3:0] TX_EN_RST = 4'h0;
  localparam logic BIST_OFF_RST = 1'b1;
  localparam logic [6:0] COMMA_POS = 7'h7c;
  localparam logic [6:0] COMMA_NEG = 7'h03;
  localparam logic [9:0] K285_POS = 10'h17c;
  localparam logic [9:0] K285_NEG = 10'h283;

endpackage : rxfmt_pkg

// file: tb_rx_output_parity_power_latch.sv
// tb_rx_output_parity_power_latch: self-checking bench, random plus corners
// assumes: link_char_src on the link side, this module is bus master
`timescale 1ns/1ps
`default_nettype none
module tb_rx_output_parity_power_latch;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, drst_n, rxs, txs;
  logic [3:0] awaddr, araddr, bus, txen, v;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs, sig, rclk, pwr, tlp, lfi, oclk, par, poe;
  logic [1:0][9:0] raw;
  logic [1:0][7:0] dd, dout;
  logic [1:0][2:0] ds, sout;
  logic [15:0] lf;
  logic [11:0] e, m;
  logic [9:0] r;
  int num_errors, comparisons, cyc;
  rx_output_parity_power_latch dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .device_reset_n(drst_n), .rx_latch_strobe(rxs), .tx_latch_strobe(txs),
    .chan_enable_bus(bus), .rec_clk(rclk), .sig_detect(sig),
    .link_raw_char(raw), .link_dec_data(dd), .link_dec_status(ds),
    .rx_power_en(pwr), .tx_driver_en(txen), .tx_logic_power(tlp),
    .link_fault_ind_n(lfi), .rx_output_clock(oclk), .rx_data_bits(dout),
    .rx_status_bits(sout), .rx_parity_out(par), .rx_parity_out_oe(poe));
  link_char_src link_u (.rec_clk(rclk), .raw(raw), .dd(dd), .ds(ds));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // {parity, status, data} one character should leave behind
  function automatic logic [11:0] exp_word(input logic [1:0] dec,
    input logic [1:0] pc, input logic [9:0] c, input logic [7:0] d,
    input logic [2:0] s);
    logic [7:0] xd;
    logic [2:0] xs;
    logic p;
    xd = (dec == 2'h0) ? c[9:2] : d;
    xs = (dec == 2'h0) ? {c == rxfmt_pkg::K285_POS ||
      c == rxfmt_pkg::K285_NEG, c[0], c[1]} : s;
    p = (pc == 2'h2) ? ~^{xd, xs} : (dec == 2'h0) ? ~^{xd, xs[1:0]} : ~^xd;
    return {p, xs, xd};
  endfunction : exp_word
  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 32'(bresp), 32'(rxfmt_pkg::RESP_OKAY));
  endtask : wr
  task automatic rdr(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rdr
  // one character on both links, bypass and full parity; c_out should stand
  // in the register afterwards and ck is the expected output clock level
  task automatic hr_step(input logic [9:0] c_in, input logic [9:0] c_out,
    input logic ck);
    fork
      link_u.send(0, c_in, 8'h00, 3'h0);
      link_u.send(1, ~c_in, 8'h00, 3'h0);
    join
    @(negedge aclk);
    for (int c = 0; c < 2; c++) begin
      e = exp_word(2'h0, 2'h2, (c == 0) ? c_out : ~c_out, 8'h00, 3'h0);
      chk("word hr", 32'({par[c], sout[c], dout[c]}), 32'(e));
      chk("out clock", 32'(oclk[c]), 32'(ck));
    end
  endtask : hr_step
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // ****************************************
  // clock, timeout, tests
  // ****************************************
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, rxs, txs} = '0;
    {awaddr, araddr, wdata, bus, sig} = '0;
    drst_n = 1'b1;
    lf = 16'h0047;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(rxfmt_pkg::CTRL_ADDR);
    chk("ctrl reset", rd, rxfmt_pkg::CTRL_RST);
    rdr(rxfmt_pkg::STAT_ADDR);
    chk("stat reset", rd, 32'h0000_0400);
    rdr(4'h8);
    chk("unmapped resp", 32'(rs), 32'(rxfmt_pkg::RESP_SLVERR));
    chk("unmapped data", rd, 32'h0);
    $display("test reset and map done");
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      v = (i == 0) ? 4'h5 : (i == 1) ? 4'ha : (i == 7) ? 4'hf : lf[3:0];
      @(posedge aclk);
      rxs <= 1'b1;
      txs <= 1'b1;
      bus <= v;
      sig <= lf[5:4];
      repeat (6) @(posedge aclk);
      chk("rx power", 32'(pwr), 32'({v[2], v[0]}));
      chk("tx drivers", 32'(txen), 32'(v));
      chk("tx logic", 32'(tlp), 32'({|v[3:2], |v[1:0]}));
      chk("fault", 32'(lfi), 32'({v[2], v[0]} & lf[5:4]));
      rxs <= 1'b0;
      txs <= 1'b0;
      repeat (5) @(posedge aclk);
      bus <= ~v;
      repeat (6) @(posedge aclk);
      chk("rx held", 32'(pwr), 32'({v[2], v[0]}));
      chk("tx held", 32'(txen), 32'(v));
    end
    $display("test enable latches done");
    wr(rxfmt_pkg::CTRL_ADDR, 32'h0000_0905);
    rdr(rxfmt_pkg::STAT_ADDR);
    chk("self-test on", 32'(rd[10]), 32'h0);
    @(posedge aclk);
    drst_n <= 1'b0;
    repeat (5) @(posedge aclk);
    drst_n <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("rst rx", 32'(pwr), 32'h0);
    chk("rst tx", 32'(txen), 32'h0);
    rdr(rxfmt_pkg::STAT_ADDR);
    chk("rst self-test", 32'(rd[10]), 32'h1);
    $display("test device reset done");
    // strobes left high: latches transparent
    rxs <= 1'b1;
    txs <= 1'b1;
    // no settling time modelled after re-enable
    bus <= 4'hf;
    sig <= 2'h3;
    for (int dec = 0; dec < 3; dec++) begin
      for (int pc = 0; pc < 3; pc++) begin
        // clock select mid, full framing pattern, full rate, framer off
        wr(rxfmt_pkg::CTRL_ADDR, 32'h110 | 32'(pc << 2) | 32'(dec));
        m = (pc == 0) ? 12'h7ff : 12'hfff;
        for (int k = 0; k < 4; k++) begin
          lf = lfsr(lf);
          r = (k == 0) ? rxfmt_pkg::K285_POS : (k == 1) ?
            rxfmt_pkg::K285_NEG : lf[9:0];
          fork
            link_u.send(0, r, lf[7:0], lf[2:0]);
            link_u.send(1, ~r, lf[15:8], lf[15:13]);
          join
          @(negedge aclk);
          for (int c = 0; c < 2; c++) begin
            e = (c == 0) ? exp_word(2'(dec), 2'(pc), r, lf[7:0], lf[2:0]) :
              exp_word(2'(dec), 2'(pc), ~r, lf[15:8], lf[15:13]);
            chk("word", 32'({par[c], sout[c], dout[c]} & m), 32'(e & m));
            chk("parity drive", 32'(poe[c]), 32'(pc != 0));
          end
        end
      end
    end
    $display("test output word and parity done");
    // 36 characters so far: half-rate phase starts low
    // low-latency framer on the comma pattern: frame must meet a rise
    wr(rxfmt_pkg::CTRL_ADDR, 32'h0000_0588);
    hr_step(10'h155, 10'h155, 1'b1);
    hr_step(rxfmt_pkg::K285_POS, rxfmt_pkg::K285_POS, 1'b1);
    hr_step(10'h155, 10'h155, 1'b0);
    // multi-byte framer: clock untouched, data delayed one character
    wr(rxfmt_pkg::CTRL_ADDR, 32'h0000_05b8);
    hr_step(10'h155, 10'h155, 1'b1);
    hr_step(rxfmt_pkg::K285_POS, rxfmt_pkg::K285_POS, 1'b0);
    hr_step(10'h155, rxfmt_pkg::K285_POS, 1'b1);
    hr_step(10'h155, 10'h155, 1'b0);
    $display("test half rate framer done");
    report_and_stop();
  end
endmodule : tb_rx_output_parity_power_latch
`default_nettype wire
